//--- include/ast_pkg.sv
// constants for the asynchronous serial transceiver
package ast_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [3:0] AST_OFF_CMD      = 4'h0;
    localparam logic [3:0] AST_OFF_CTRL     = 4'h4;
    localparam logic [3:0] AST_OFF_TXDATA   = 4'h8;
    localparam logic [3:0] AST_OFF_TXSTAT   = 4'hc;
    localparam logic [3:0] AST_OFF_RXDATA   = 4'h0;
    localparam logic [3:0] AST_OFF_RXSTAT   = 4'h4;
    localparam logic [3:0] AST_OFF_IRQSTAT  = 4'h8;
    localparam logic [3:0] AST_OFF_IRQEN    = 4'hc;
    // page select: bit 4 of the address picks the upper register page
    localparam int         AST_PAGE_BIT     = 4;
    localparam int         AST_IRQCLR_BIT   = 5;
    // command register fields
    localparam int         AST_CMD_WL       = 0;
    localparam int         AST_CMD_PE       = 1;
    localparam int         AST_CMD_PM       = 2;
    localparam int         AST_CMD_RC_LO    = 3;
    localparam int         AST_CMD_RXB      = 6;
    localparam int         AST_CMD_XTAL     = 7;
    // control register fields
    localparam int         AST_CTL_BR_LO    = 0;
    localparam int         AST_CTL_XTX      = 3;
    localparam int         AST_CTL_XRX      = 4;
    localparam int         AST_CTL_TXEN     = 5;
    localparam int         AST_CTL_RXA      = 6;
    localparam int         AST_CTL_ECHO     = 7;
    // reset values
    localparam logic [7:0] AST_CMD_RST      = 8'h01;
    localparam logic [7:0] AST_CTRL_RST     = 8'h05;
    localparam logic [7:0] AST_TXDATA_RST   = 8'h00;
    // interrupt status bits
    localparam int         AST_IRQ_RXFULL   = 0;
    localparam int         AST_IRQ_TXEMPTY  = 1;
    localparam int         AST_IRQ_W        = 2;
    // oversampling of each bit by the receiver
    localparam int         AST_OVS          = 16;
    // base rate 115200 * 16, in hz
    localparam int         AST_BASE_HZ      = 1843200;
    localparam int         AST_CLK_HZ       = 100000000;
endpackage : ast_pkg

//--- src/ast_uart.sv
// asynchronous serial transceiver with wishbone register access
// Summary of operation
// - transmit and receive run together, one holding register each way
// - internal generator offers eleven rates, set by baud and prescale fields
// - command bit 7 picks rc (0) or crystal (1) clock; resets 0
// - command bit 0 gives 8 data bits when 1, 7 when 0; resets 1
// - command bit 1 adds parity on transmit and checks it on receive
// - command bit 2 selects odd parity at 0, even at 1; resets 0
// - receiver flags start, parity, framing and overrun errors
// - control bit 7 echoes the receive line onto transmit; resets 0
// - control bits 4 and 3 invert receive and transmit pins
// - transmit only while control bit 5 set; receive enabled separately
// - two interrupts: receive holding full, transmit holding empty
// - status bit 0 set on data write, cleared on load; bit 1 shifting
// - reception enabled when either receive enable bit is 1
// - in echo, transmit line equals receive line xor transmit inversion
// - each word is sent and received least significant bit first
// - transmit empty interrupt fires when the held word enters the shifter
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ast_uart
    import ast_pkg::*;
#(
    parameter int CLK_HZ = ast_pkg::AST_CLK_HZ
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        rx_pin,
    output var  logic        tx_pin,
    output logic             irq_rx_full,
    output logic             irq_tx_empty,
    output logic             irq_o
);
    import ast_pkg::*;

    // elaboration check: the base prescaler needs at least two clocks
    if (CLK_HZ < 2 * AST_BASE_HZ)
    begin : g_clk_check
        $error("ast_uart: clock too slow for the oversampled base rate");
    end

    // divider to the 16x tick of 115200 baud
    localparam int BASE_DIV = CLK_HZ / AST_BASE_HZ;
    localparam int BDW      = $clog2(BASE_DIV + 1);

    logic [7:0]  cmd_q, ctrl_q, txd_q, rxd_q;
    logic [1:0]  irq_stat_q, irq_en_q;
    logic        ack_q;
    logic        tx_full_q, rx_full_q;
    logic        err_s_q, err_p_q, err_f_q, err_o_q;
    logic [1:0]  rx_sync_q;

    // field decode
    wire        wl8      = cmd_q[AST_CMD_WL];
    wire        par_en   = cmd_q[AST_CMD_PE];
    wire        par_even = cmd_q[AST_CMD_PM];
    wire [2:0]  rc_sel   = cmd_q[AST_CMD_RC_LO +: 3];
    wire        xtal_sel = cmd_q[AST_CMD_XTAL];
    wire [2:0]  baud_sel = ctrl_q[AST_CTL_BR_LO +: 3];
    wire        tx_inv   = ctrl_q[AST_CTL_XTX];
    wire        rx_inv   = ctrl_q[AST_CTL_XRX];
    wire        tx_en    = ctrl_q[AST_CTL_TXEN];
    wire        echo_en  = ctrl_q[AST_CTL_ECHO];
    wire        rx_en    = cmd_q[AST_CMD_RXB] | ctrl_q[AST_CTL_RXA];
    wire [3:0]  nbits    = wl8 ? 4'h8 : 4'h7;

    // one clock feeds both sources here; the source bit only picks the
    // rate table, so rc and crystal settings give their printed rates
    function automatic logic [11:0] rate_div(input logic xt,
                                             input logic [2:0] rc,
                                             input logic [2:0] br);
        logic [11:0] d;
        d = 12'h000;
        if (xt)
            d = 12'h180 >> br;                                // 300..38400
        else
            unique case (br)
                3'h7: d = 12'h001;                            // 115200
                3'h6: d = 12'h002;                            // 57600
                3'h5: d = 12'h00c;                            // 9600
                3'h4: d = 12'h008;                            // 14400
                3'h3: d = 12'h018;                            // 4800
                3'h2: d = 12'h030;                            // 2400
                3'h1: d = 12'h060;                            // 1200
                3'h0: d = 12'h0c0;                            // 600
            endcase
        if (rc == 3'h7)
            d = 12'h000;
        return (d == 12'h000) ? 12'h001 : d;
    endfunction : rate_div

    wire [11:0] rdiv = rate_div(xtal_sel, rc_sel, baud_sel);

    // baud generator: base prescale then rate divide gives 16x tick
    logic [BDW-1:0] pre_q;
    logic [11:0]    rcnt_q;
    wire            pre_hit = (pre_q == BDW'(BASE_DIV - 1));
    wire            tick    = pre_hit && (rcnt_q == rdiv - 12'h001);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_q  <= '0;
            rcnt_q <= 12'h000;
        end
        else if (clk_en)
        begin
            pre_q  <= pre_hit ? '0 : pre_q + 1'b1;
            if (pre_hit)
                rcnt_q <= tick ? 12'h000 : rcnt_q + 12'h001;
        end
    end

    // wishbone decode
    wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        wr       = req & wb_we_i & wb_sel_i[0];
    wire        rd       = req & ~wb_we_i;
    wire        hi_pg    = wb_adr_i[AST_PAGE_BIT];
    wire        clr_pg   = wb_adr_i[AST_IRQCLR_BIT];
    wire [3:0]  off      = wb_adr_i[3:0];
    wire        wr_cmd   = wr & ~clr_pg & ~hi_pg & (off == AST_OFF_CMD);
    wire        wr_ctrl  = wr & ~clr_pg & ~hi_pg & (off == AST_OFF_CTRL);
    wire        wr_txd   = wr & ~clr_pg & ~hi_pg & (off == AST_OFF_TXDATA);
    wire        wr_rxst  = wr & ~clr_pg & hi_pg & (off == AST_OFF_RXSTAT);
    wire        wr_irqen = wr & ~clr_pg & hi_pg & (off == AST_OFF_IRQEN);
    wire        wr_irqcl = wr & clr_pg;
    wire        rd_rxd   = rd & ~clr_pg & hi_pg & (off == AST_OFF_RXDATA);

    // receiver state
    typedef enum {AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_PAR,
                  AST_RX_STOP} ast_rx_e;
    ast_rx_e     rx_st_q;
    logic [3:0]  rx_os_q, rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_perr_q, rx_serr_q;
    wire         rxl      = rx_sync_q[1] ^ rx_inv;
    wire         rx_mid   = tick && (rx_os_q == 4'h7);
    wire         rx_done  = rx_mid && (rx_st_q == AST_RX_STOP);
    wire         rx_busy  = (rx_st_q != AST_RX_IDLE);

    // transmitter state
    typedef enum {AST_TX_IDLE, AST_TX_START, AST_TX_DATA, AST_TX_PAR,
                  AST_TX_STOP} ast_tx_e;
    ast_tx_e     tx_st_q;
    logic [3:0]  tx_os_q, tx_bit_q;
    logic [7:0]  tx_sh_q;
    logic        tx_par_q, tx_line_q;
    wire         tx_bend  = tick && (tx_os_q == 4'hf);
    wire         tx_load  = tx_full_q && tx_en &&
                            ((tx_st_q == AST_TX_IDLE) ||
                             (tx_st_q == AST_TX_STOP && tx_bend));
    wire         tx_busy  = (tx_st_q != AST_TX_IDLE);

    // configuration and holding registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_q    <= AST_CMD_RST;
            ctrl_q   <= AST_CTRL_RST;
            txd_q    <= AST_TXDATA_RST;
            irq_en_q <= 2'h0;
        end
        else if (clk_en)
        begin
            if (wr_cmd)   cmd_q    <= wb_dat_i[7:0];
            if (wr_ctrl)  ctrl_q   <= wb_dat_i[7:0];
            if (wr_txd)   txd_q    <= wb_dat_i[7:0];
            if (wr_irqen) irq_en_q <= wb_dat_i[AST_IRQ_W-1:0];
        end
    end

    // flags; hardware set wins over software clear
    wire [1:0] irq_set = {tx_load, rx_done};
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_full_q  <= 1'b0;
            rx_full_q  <= 1'b0;
            err_o_q    <= 1'b0;
            irq_stat_q <= 2'h0;
            ack_q      <= 1'b0;
            rx_sync_q  <= 2'h3;
        end
        else if (clk_en)
        begin
            ack_q     <= req;
            rx_sync_q <= {rx_sync_q[0], rx_pin};
            if (wr_txd)       tx_full_q <= 1'b1;
            else if (tx_load) tx_full_q <= 1'b0;
            if (rx_done)      rx_full_q <= 1'b1;
            else if (rd_rxd)  rx_full_q <= 1'b0;
            if (rx_done && rx_full_q) err_o_q <= 1'b1;
            else if (wr_rxst)         err_o_q <= 1'b0;
            irq_stat_q <= irq_set |
                          (irq_stat_q & ~(wr_irqcl ? wb_dat_i[1:0] : 2'h0));
        end
    end

    // receiver: sample mid-bit at 16x, lsb first
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st_q   <= AST_RX_IDLE;
            rx_os_q   <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
            rx_perr_q <= 1'b0;
            rx_serr_q <= 1'b0;
            rxd_q     <= 8'h00;
            err_s_q   <= 1'b0;
            err_p_q   <= 1'b0;
            err_f_q   <= 1'b0;
        end
        else if (clk_en && tick)
        begin
            rx_os_q <= rx_os_q + 4'h1;
            unique case (rx_st_q)
                AST_RX_IDLE:
                    if (rx_en && !rxl)
                    begin
                        rx_st_q <= AST_RX_START;
                        rx_os_q <= 4'h0;
                    end
                AST_RX_START:
                    if (rx_os_q == 4'h7)
                    begin
                        rx_serr_q <= rxl;
                        rx_perr_q <= par_even ? 1'b0 : 1'b1;
                        rx_bit_q  <= 4'h0;
                        rx_sh_q   <= 8'h00;
                        rx_st_q   <= AST_RX_DATA;
                        rx_os_q   <= 4'h8;
                    end
                AST_RX_DATA:
                    if (rx_os_q == 4'h7)
                    begin
                        rx_sh_q   <= {rxl, rx_sh_q[7:1]};
                        rx_perr_q <= rx_perr_q ^ rxl;
                        rx_bit_q  <= rx_bit_q + 4'h1;
                        if (rx_bit_q == nbits - 4'h1)
                            rx_st_q <= par_en ? AST_RX_PAR : AST_RX_STOP;
                    end
                AST_RX_PAR:
                    if (rx_os_q == 4'h7)
                    begin
                        rx_perr_q <= rx_perr_q ^ rxl;
                        rx_st_q   <= AST_RX_STOP;
                    end
                AST_RX_STOP:
                    if (rx_os_q == 4'h7)
                    begin
                        rxd_q   <= wl8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
                        err_s_q <= rx_serr_q;
                        err_p_q <= par_en & rx_perr_q;
                        err_f_q <= ~rxl;
                        rx_st_q <= AST_RX_IDLE;
                    end
            endcase
        end
    end

    // transmitter: start, data lsb first, parity, one stop
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_st_q   <= AST_TX_IDLE;
            tx_os_q   <= 4'h0;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 8'h00;
            tx_par_q  <= 1'b0;
            tx_line_q <= 1'b1;
        end
        else if (clk_en)
        begin
            if (tick)
                tx_os_q <= tx_os_q + 4'h1;
            if (tx_load)
            begin
                tx_sh_q   <= txd_q;
                tx_par_q  <= par_even ? 1'b0 : 1'b1;
                tx_bit_q  <= 4'h0;
                tx_os_q   <= 4'h0;
                tx_line_q <= 1'b0;
                tx_st_q   <= AST_TX_START;
            end
            else if (tx_bend)
            begin
                unique case (tx_st_q)
                    AST_TX_IDLE:
                        tx_line_q <= 1'b1;
                    AST_TX_START:
                    begin
                        tx_line_q <= tx_sh_q[0];
                        tx_st_q   <= AST_TX_DATA;
                    end
                    AST_TX_DATA:
                    begin
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == nbits - 4'h1)
                        begin
                            tx_line_q <= par_en ?
                                         tx_par_q ^ tx_sh_q[0] : 1'b1;
                            tx_st_q   <= par_en ? AST_TX_PAR : AST_TX_STOP;
                        end
                        else
                            tx_line_q <= tx_sh_q[1];
                    end
                    AST_TX_PAR:
                    begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= AST_TX_STOP;
                    end
                    AST_TX_STOP:
                        tx_st_q <= AST_TX_IDLE;
                endcase
            end
        end
    end

    // pin output is registered; echo reuses the synchronised rx level
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_pin <= 1'b1;
        else if (clk_en)
            tx_pin <= echo_en ? (rx_sync_q[1] ^ tx_inv) :
                      (tx_en ? tx_line_q : 1'b1) ^ tx_inv;
    end

    // read mux
    wire [7:0] txst = {6'h00, tx_busy, tx_full_q};
    wire [7:0] rxst = {2'h0, err_s_q, err_p_q, err_f_q, err_o_q,
                       rx_busy, rx_full_q};
    wire [7:0] lo_rd = (off == AST_OFF_CMD)    ? cmd_q :
                       (off == AST_OFF_CTRL)   ? ctrl_q :
                       (off == AST_OFF_TXDATA) ? txd_q :
                       (off == AST_OFF_TXSTAT) ? txst : 8'h00;
    wire [7:0] hi_rd = (off == AST_OFF_RXDATA)  ? rxd_q :
                       (off == AST_OFF_RXSTAT)  ? rxst :
                       (off == AST_OFF_IRQSTAT) ? {6'h00, irq_stat_q} :
                       (off == AST_OFF_IRQEN)   ? {6'h00, irq_en_q} : 8'h00;
    wire [7:0] rd_d  = clr_pg ? 8'h00 : (hi_pg ? hi_rd : lo_rd);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            wb_dat_o <= 32'h0000_0000;
        else if (clk_en && req)
            wb_dat_o <= {24'h00_0000, rd_d};
    end

    assign wb_ack_o     = ack_q;
    assign irq_rx_full  = irq_stat_q[AST_IRQ_RXFULL] &
                          irq_en_q[AST_IRQ_RXFULL];
    assign irq_tx_empty = irq_stat_q[AST_IRQ_TXEMPTY] &
                          irq_en_q[AST_IRQ_TXEMPTY];
    assign irq_o        = irq_rx_full | irq_tx_empty;
endmodule : ast_uart
`default_nettype wire

//--- tb/ast_remote.sv
// far-end serial device model: sends on rx, decodes tx
`timescale 1ns/1ps
`default_nettype none
module ast_remote
    import ast_pkg::*;
#(
    parameter int CLK_HZ = AST_CLK_HZ
)(
    input wire logic       sys_clk,
    input wire logic       tx_line,
    output var logic       rx_line,
    input wire logic [3:0] n_bits,
    input wire logic       par_en,
    input wire logic       par_even
);
    localparam int BIT_CYC = AST_OVS * (CLK_HZ / AST_BASE_HZ);
    logic [7:0] got_data;
    logic       got_par;
    logic       got_stop;
    int         got_cnt;
    initial rx_line = 1'b1;
    task automatic bit_out(input logic v);
        rx_line <= v;
        repeat (BIT_CYC) @(posedge sys_clk);
    endtask : bit_out
    // start, data lsb first, parity, one stop, then idle high
    task automatic send(input logic [7:0] d, input logic bad_par);
        @(posedge sys_clk);
        bit_out(1'b0);
        for (int i = 0; i < n_bits; i++) bit_out(d[i]);
        if (par_en) bit_out(^d ^ !par_even ^ bad_par);
        bit_out(1'b1);
    endtask : send
    task automatic set_line(input logic v);
        @(posedge sys_clk);
        rx_line <= v;
    endtask : set_line
    // mid-bit sampling of the device output
    initial
    begin
        got_cnt = 0;
        forever
        begin
            @(posedge sys_clk);
            if (tx_line === 1'b0)
            begin
                repeat (BIT_CYC / 2) @(posedge sys_clk);
                got_data = 8'h00;
                for (int i = 0; i < n_bits; i++)
                begin
                    repeat (BIT_CYC) @(posedge sys_clk);
                    got_data[i] = tx_line;
                end
                if (par_en) repeat (BIT_CYC) @(posedge sys_clk);
                got_par = tx_line;
                repeat (BIT_CYC) @(posedge sys_clk);
                got_stop = tx_line;
                got_cnt++;
            end
        end
    end
endmodule : ast_remote
`default_nettype wire

//--- tb/ast_uart_sva.sv
// port-level checks for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_uart_sva
    import ast_pkg::*;
#(
    parameter int CLK_HZ = AST_CLK_HZ
)(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_pin,
    input wire logic        irq_rx_full,
    input wire logic        irq_tx_empty,
    input wire logic        irq_o
);
    localparam int BIT_CYC = AST_OVS * (CLK_HZ / AST_BASE_HZ);
    logic [15:0] low_run_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // low stretch length; a stuck line shows as an endless run
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            low_run_q <= 16'h0000;
        else if (tx_pin)
            low_run_q <= 16'h0000;
        else
            low_run_q <= low_run_q + 16'h0001;
    end
    ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o
        && clk_en) |=> wb_ack_o) else $error("ack not one cycle after take");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    irq_merge_a: assert property (irq_o == (irq_rx_full | irq_tx_empty))
        else $error("merged interrupt wrong");
    bit_low_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
        else $error("short low on serial out");
    bit_high_a: assert property ($rose(tx_pin) |-> tx_pin [*8])
        else $error("short high on serial out");
    frame_low_a: assert property (low_run_q <= 10 * BIT_CYC)
        else $error("serial out low beyond a frame");
    empty_start_a: assert property ($rose(irq_tx_empty) |-> ##[1:2]
        $fell(tx_pin)) else $error("empty interrupt without start bit");
endmodule : ast_uart_sva
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ast_pkg::*;
    localparam int CLK_HZ = AST_CLK_HZ;
    localparam logic [7:0] RST_V [4] = '{AST_CMD_RST, AST_CTRL_RST,
                                         AST_TXDATA_RST, 8'h00};
    // last mode: crystal source with prescale 7, forced to the fastest rate
    localparam logic [7:0] M_CMD [4] = '{8'h01, 8'h03, 8'h46, 8'hbf};
    localparam logic [7:0] M_CTL [4] = '{8'h67, 8'h67, 8'h27, 8'h67};
    logic        sys_clk, rst_b, cyc, stb, we, ack, rx, tx;
    logic        irq_rx, irq_tx, irq, par_en, par_even, v, en;
    logic [5:0]  adr;
    logic [3:0]  sel, n_bits;
    logic [31:0] dat_w, dat_r, q;
    logic [7:0]  d, dr;
    int          miscompares, n_compared, c0, n;
    ast_uart #(.CLK_HZ(CLK_HZ)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .rx_pin(rx), .tx_pin(tx), .irq_rx_full(irq_rx),
        .irq_tx_empty(irq_tx), .irq_o(irq));
    ast_remote #(.CLK_HZ(CLK_HZ)) rem (.sys_clk(sys_clk), .tx_line(tx),
        .rx_line(rx), .n_bits(n_bits), .par_en(par_en), .par_even(par_even));
    initial
    begin
        {sys_clk, rst_b, cyc, stb, we, par_en, par_even} = 7'h00;
        {adr, sel, dat_w, miscompares, n_compared} = '0;
        n_bits = 4'h8;
        en = 1'b1;
    end
    always #5 sys_clk = ~sys_clk;
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hf, wd};
        n = 0;
        do begin @(posedge sys_clk); n++; end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) chk(0, 1, "bus timeout");
        if (ack !== 1'b1) tally_and_finish();
        q = dat_r;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic wait_tx;
        for (int i = 0; i < 20000 && rem.got_cnt == c0; i++)
            @(posedge sys_clk);
        chk(rem.got_cnt, c0 + 1, "frame count");
        if (rem.got_cnt == c0) tally_and_finish();
        chk(rem.got_stop, 1'b1, "stop bit");
    endtask : wait_tx
    function automatic logic exp_par(input logic [7:0] x, input logic e);
        return ^x ^ !e;
    endfunction : exp_par
    // main sequence
    initial
    begin
        void'($urandom(79));
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 6'(i * 4), 0);
            chk(q, {24'h0, RST_V[i]}, "reset value");
        end
        bus(1'b0, 6'h20, 0);
        chk(q, 0, "unmapped read");
        bus(1'b1, 6'h1c, 3);
        bus(1'b1, AST_OFF_CTRL, 32'h47);
        d = 8'($urandom);
        c0 = rem.got_cnt;
        bus(1'b1, AST_OFF_TXDATA, d);
        bus(1'b0, AST_OFF_TXSTAT, 0);
        chk(q, 1, "word held while off");
        bus(1'b0, 6'h18, 0);
        chk(q, 0, "no empty event yet");
        bus(1'b1, AST_OFF_CTRL, 32'h67);
        bus(1'b0, AST_OFF_TXSTAT, 0);
        chk(q, 2, "shifting status");
        wait_tx();
        chk(rem.got_data, d, "sent word");
        bus(1'b0, 6'h18, 0);
        chk(q[1], 1'b1, "empty event");
        // word length and parity modes, both directions at once
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, AST_OFF_CMD, M_CMD[m]);
            bus(1'b1, AST_OFF_CTRL, M_CTL[m]);
            n_bits = M_CMD[m][0] ? 4'h8 : 4'h7;
            {par_even, par_en} = M_CMD[m][2:1];
            d = 8'($urandom) & (M_CMD[m][0] ? 8'hff : 8'h7f);
            dr = 8'($urandom) & (M_CMD[m][0] ? 8'hff : 8'h7f);
            c0 = rem.got_cnt;
            fork
                bus(1'b1, AST_OFF_TXDATA, d);
                rem.send(dr, 1'b0);
            join
            wait_tx();
            chk(rem.got_data, d, "sent word");
            if (par_en)
                chk(rem.got_par, exp_par(d, par_even), "par");
            @(negedge sys_clk);
            chk(irq_rx, 1'b1, "rx full interrupt");
            bus(1'b0, 6'h10, 0);
            chk(q, dr, "received word");
            bus(1'b0, 6'h14, 0);
            chk(q, 0, "clean rx status");
            // clear events so the next mode must raise them afresh
            bus(1'b1, 6'h20, 3);
        end
        // masked interrupt, parity error, then overrun
        bus(1'b1, 6'h1c, 0);
        bus(1'b1, 6'h20, 3);
        bus(1'b1, AST_OFF_CMD, 8'h03);
        {n_bits, par_even, par_en} = {4'h8, 2'b01};
        rem.send(8'($urandom), 1'b1);
        bus(1'b0, 6'h14, 0);
        chk(q, 32'h11, "parity error");
        chk(irq, 1'b0, "masked interrupt");
        bus(1'b0, 6'h18, 0);
        chk(q[0], 1'b1, "sticky rx event");
        rem.send(8'($urandom), 1'b0);
        bus(1'b0, 6'h14, 0);
        chk(q, 32'h05, "overrun");
        bus(1'b1, 6'h14, 0);
        bus(1'b0, 6'h10, 0);
        bus(1'b0, 6'h14, 0);
        chk(q, 0, "errors cleared");
        bus(1'b1, 6'h20, 3);
        bus(1'b0, 6'h18, 0);
        chk(q, 0, "events cleared");
        // echo through the inverted output
        bus(1'b1, AST_OFF_CTRL, 32'h88);
        for (int k = 0; k < 4; k++)
        begin
            v = 1'($urandom);
            rem.set_line(v);
            repeat (20) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(tx, !v, "echo level");
        end
        // low clock enable freezes the echo path, then it resumes
        @(posedge sys_clk);
        en <= 1'b0;
        rem.set_line(!v);
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(tx, !v, "frozen output");
        @(posedge sys_clk);
        en <= 1'b1;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(tx, v, "echo resumes");
        bus(1'b1, AST_OFF_CTRL, 32'h08);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(tx, 1'b0, "inverted idle");
        tally_and_finish();
    end
endmodule : tb
bind ast_uart ast_uart_sva #(.CLK_HZ(CLK_HZ)) chk_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_pin(tx_pin), .irq_rx_full(irq_rx_full),
    .irq_tx_empty(irq_tx_empty), .irq_o(irq_o));
`default_nettype wire
